// *** rtl/prcg_pkg.sv ***
/*
  Constants, types and helpers for the peripheral reset and clock gating bank.
  Assumes a single system clock and a word-aligned register port with byte lanes.
*/
// How it works
// R1: bits 31 and 30 of the reset register hold the two audio extensions in reset.
// R2: bits 18 to 16 of the reset register hold general timers in reset.
// R3: bits 1 and 0 of the reset register hold the advanced timers in reset.
// R4: bits 13,12 reset serial units; bits 5,4 reset the transceivers.
// R5: bit 8 resets the converter interface, 14 sysconfig, 29 calibrator.
// R6: reserved bits read as zero; software writes them as zero.
// R7: every clock enable bit gates its clock, zero is off, resets to zero.
// R8: in reduced mode, receive or transmit enable also turns on the reference clock.
// R9: bits 7 to 0 of the first high-speed enable gate ports H to A.
// R10: enable registers answer without wait states, by word, half-word or byte.
// R11: bit 11 of the first-bus enable gates the window watchdog clock.
// R12: bit 28 gates power control, bits 27 to 25 the three CAN clocks.
// R13: a reset bit stays set until software clears it.
// R14: clocks are gated glitch-free, no shortened pulses.
package prcg_pkg;

  localparam int ADDR_W = 8;
  localparam int LANES  = 4;

  typedef logic [31:0]       prcg_word_type;
  typedef logic [ADDR_W-1:0] prcg_addr_type;
  typedef logic [LANES-1:0]  prcg_lane_type;

  localparam prcg_addr_type OFF_BUS2_RST = 8'h00;
  localparam prcg_addr_type OFF_HS1_EN   = 8'h04;
  localparam prcg_addr_type OFF_HS2_EN   = 8'h08;
  localparam prcg_addr_type OFF_HS3_EN   = 8'h0c;
  localparam prcg_addr_type OFF_BUS1_EN  = 8'h10;

  localparam prcg_word_type MASK_BUS2_RST = 32'he017_7133;
  localparam prcg_word_type MASK_HS1_EN   = 32'h1f40_10ff;
  localparam prcg_word_type MASK_HS2_EN   = 32'h0000_80d0;
  localparam prcg_word_type MASK_HS3_EN   = 32'h0000_0003;
  localparam prcg_word_type MASK_BUS1_EN  = 32'hfefe_c900;
  localparam prcg_word_type RESET_VALUE   = 32'h0000_0000;

  localparam int LANE0 = 0;
  localparam int LANE1 = 1;
  localparam int LANE2 = 2;
  localparam int LANE3 = 3;

  localparam int BIT_AUDIO_B    = 31;
  localparam int BIT_AUDIO_A    = 30;
  localparam int BIT_CALIB      = 29;
  localparam int BIT_FDX_AUDIO  = 20;
  localparam int BIT_GTIM_C     = 18;
  localparam int BIT_GTIM_B     = 17;
  localparam int BIT_GTIM_A     = 16;
  localparam int BIT_SYSCFG     = 14;
  localparam int BIT_SPI_D      = 13;
  localparam int BIT_SPI_A      = 12;
  localparam int BIT_CONV       = 8;
  localparam int BIT_XCVR_F     = 5;
  localparam int BIT_XCVR_A     = 4;
  localparam int BIT_ATIM_B     = 1;
  localparam int BIT_ATIM_A     = 0;
  localparam int BIT_ETH_RX     = 27;
  localparam int BIT_ETH_TX     = 26;
  localparam int BIT_PORT_H     = 7;
  localparam int BIT_PORT_A     = 0;
  localparam int BIT_WWDG       = 11;
  localparam int BIT_PWR        = 28;
  localparam int BIT_CAN_C      = 27;
  localparam int BIT_CAN_A      = 25;

  // word match; the two low address bits are ignored, the byte enables select lanes
  function automatic logic prcg_hit(input prcg_addr_type addr, input prcg_addr_type off);
    return addr[ADDR_W-1:2] == off[ADDR_W-1:2];
  endfunction : prcg_hit

  function automatic prcg_word_type prcg_merge(input prcg_word_type old_v, input prcg_word_type wd,
                                               input prcg_lane_type be, input prcg_word_type mask);
    prcg_word_type res;
    res = old_v;
    for (int i = 0; i < LANES; i++) begin
      if (be[i]) begin
        res[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return res & mask;
  endfunction : prcg_merge

endpackage : prcg_pkg

// *** rtl/prcg_wr_if.sv ***
/*
  Write request carrier from the register port to the register slices.
  Assumes all signals are on sys_clk.
*/
`timescale 1ns/1ps
interface prcg_wr_if;
  import prcg_pkg::*;
  logic          wr;
  prcg_addr_type addr;
  prcg_word_type wdata;
  prcg_lane_type be;
  modport bus_side (output wr, output addr, output wdata, output be);
  modport reg_side (input wr, input addr, input wdata, input be);
endinterface : prcg_wr_if

// *** rtl/prcg_reg_slice.sv ***
/*
  One masked 32-bit register with byte-lane writes.
  Assumes writes arrive on sys_clk through the carrier.
*/
`timescale 1ns/1ps
module prcg_reg_slice #(
  parameter prcg_pkg::prcg_addr_type OFFSET = prcg_pkg::OFF_BUS2_RST,
  parameter prcg_pkg::prcg_word_type MASK   = prcg_pkg::MASK_BUS2_RST
) (
  input  wire logic              sys_clk,
  input  wire logic              rst_n,
  prcg_wr_if.reg_side            wr_bus,
  output prcg_pkg::prcg_word_type value
);
  import prcg_pkg::*;

  wire logic          hit;
  wire prcg_word_type next_value;

  assign hit        = wr_bus.wr && prcg_hit(wr_bus.addr, OFFSET);
  assign next_value = prcg_merge(value, wr_bus.wdata, wr_bus.be, MASK);

  // bits only change on a write; nothing self-clears
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      value <= RESET_VALUE;
    end else if (hit) begin
      value <= next_value; // see R13
    end
  end
endmodule : prcg_reg_slice

// *** rtl/prcg_clk_gate.sv ***
/*
  Vector of glitch-free clock gates.
  Assumes enables change only just after the rising edge of sys_clk.
*/
`timescale 1ns/1ps
module prcg_clk_gate #(
  parameter int WIDTH = 32
) (
  input  wire logic             sys_clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] enable,
  output logic      [WIDTH-1:0] held,
  output logic      [WIDTH-1:0] gated_clk
);
  // enable is retimed in the low phase, so the and gate never cuts a high pulse
  always_ff @(negedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      held <= '0;
    end else begin
      held <= enable; // see R14
    end
  end

  assign gated_clk = {WIDTH{sys_clk}} & held;
endmodule : prcg_clk_gate

// *** rtl/prcg_top.sv ***
/*
  Peripheral reset and clock gating bank: five registers, reset lines and gated clocks.
  Assumes a master on sys_clk that never strobes read and write together.
*/
// The strobed register port and the address map were decided locally.
`timescale 1ns/1ps
module prcg_top (
  input  wire logic                   sys_clk,
  input  wire logic                   rst_n,
  input  wire prcg_pkg::prcg_addr_type reg_addr,
  input  wire prcg_pkg::prcg_word_type reg_wdata,
  input  wire prcg_pkg::prcg_lane_type reg_byte_en,
  input  wire logic                   reg_wr,
  input  wire logic                   reg_rd,
  output prcg_pkg::prcg_word_type     reg_rdata,
  input  wire logic                   rmii_mode,
  output logic                        audio_ext_b_reset,
  output logic                        audio_ext_a_reset,
  output logic                        clock_calibrator_reset,
  output logic                        fullduplex_audio_reset,
  output logic                        general_timer_c_reset,
  output logic                        general_timer_b_reset,
  output logic                        general_timer_a_reset,
  output logic                        sysconfig_unit_reset,
  output logic                        serial_periph_d_reset,
  output logic                        serial_periph_a_reset,
  output logic                        converter_interface_reset,
  output logic                        transceiver_f_reset,
  output logic                        transceiver_a_reset,
  output logic                        advanced_timer_b_reset,
  output logic                        advanced_timer_a_reset,
  output prcg_pkg::prcg_word_type     hs1_clk,
  output prcg_pkg::prcg_word_type     hs2_clk,
  output prcg_pkg::prcg_word_type     hs3_clk,
  output prcg_pkg::prcg_word_type     bus1_clk,
  output logic                        rmii_ref_clk
);
  import prcg_pkg::*;

  prcg_word_type bus2_rst;
  prcg_word_type hs1_en;
  prcg_word_type hs2_en;
  prcg_word_type hs3_en;
  prcg_word_type bus1_en;
  prcg_word_type hs1_held;
  prcg_word_type hs2_held;
  prcg_word_type hs3_held;
  prcg_word_type bus1_held;
  logic          rmii_ref_on;
  logic          rmii_ref_held;
  wire logic     next_rmii_ref_on;
  wire logic     rd_bus2_rst;
  wire logic     rd_hs1_en;
  wire logic     rd_hs2_en;
  wire logic     rd_hs3_en;
  wire logic     rd_bus1_en;
  wire prcg_word_type next_rdata;
  wire prcg_word_type rd_mask;

  prcg_wr_if wr_bus ();

  assign wr_bus.wr    = reg_wr;
  assign wr_bus.addr  = reg_addr;
  assign wr_bus.wdata = reg_wdata;
  assign wr_bus.be    = reg_byte_en;

  // reserved bits are masked inside each slice and read back zero
  prcg_reg_slice #(.OFFSET(OFF_BUS2_RST), .MASK(MASK_BUS2_RST)) u_bus2_rst ( // see R6
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .wr_bus  (wr_bus),
    .value   (bus2_rst)
  );

  prcg_reg_slice #(.OFFSET(OFF_HS1_EN), .MASK(MASK_HS1_EN)) u_hs1_en (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .wr_bus  (wr_bus),
    .value   (hs1_en)
  );

  prcg_reg_slice #(.OFFSET(OFF_HS2_EN), .MASK(MASK_HS2_EN)) u_hs2_en (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .wr_bus  (wr_bus),
    .value   (hs2_en)
  );

  prcg_reg_slice #(.OFFSET(OFF_HS3_EN), .MASK(MASK_HS3_EN)) u_hs3_en (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .wr_bus  (wr_bus),
    .value   (hs3_en)
  );

  prcg_reg_slice #(.OFFSET(OFF_BUS1_EN), .MASK(MASK_BUS1_EN)) u_bus1_en (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .wr_bus  (wr_bus),
    .value   (bus1_en)
  );

  // reset lines are the register bits themselves, held until cleared
  assign audio_ext_b_reset         = bus2_rst[BIT_AUDIO_B];   // see R1
  assign audio_ext_a_reset         = bus2_rst[BIT_AUDIO_A];   // see R1
  assign clock_calibrator_reset    = bus2_rst[BIT_CALIB];     // see R5
  assign fullduplex_audio_reset    = bus2_rst[BIT_FDX_AUDIO];
  assign general_timer_c_reset     = bus2_rst[BIT_GTIM_C];    // see R2
  assign general_timer_b_reset     = bus2_rst[BIT_GTIM_B];    // see R2
  assign general_timer_a_reset     = bus2_rst[BIT_GTIM_A];    // see R2
  assign sysconfig_unit_reset      = bus2_rst[BIT_SYSCFG];    // see R5
  assign serial_periph_d_reset     = bus2_rst[BIT_SPI_D];     // see R4
  assign serial_periph_a_reset     = bus2_rst[BIT_SPI_A];     // see R4
  assign converter_interface_reset = bus2_rst[BIT_CONV];      // see R5
  assign transceiver_f_reset       = bus2_rst[BIT_XCVR_F];    // see R4
  assign transceiver_a_reset       = bus2_rst[BIT_XCVR_A];    // see R4
  assign advanced_timer_b_reset    = bus2_rst[BIT_ATIM_B];    // see R3
  assign advanced_timer_a_reset    = bus2_rst[BIT_ATIM_A];    // see R3

  // clock gates; each bit of each enable register drives one gate
  prcg_clk_gate #(.WIDTH(32)) u_gate_hs1 ( // see R7, R9
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    .enable    (hs1_en),
    .held      (hs1_held),
    .gated_clk (hs1_clk)
  );

  prcg_clk_gate #(.WIDTH(32)) u_gate_hs2 ( // see R7
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    .enable    (hs2_en),
    .held      (hs2_held),
    .gated_clk (hs2_clk)
  );

  prcg_clk_gate #(.WIDTH(32)) u_gate_hs3 ( // see R7
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    .enable    (hs3_en),
    .held      (hs3_held),
    .gated_clk (hs3_clk)
  );

  prcg_clk_gate #(.WIDTH(32)) u_gate_bus1 ( // see R7, R11, R12
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    .enable    (bus1_en),
    .held      (bus1_held),
    .gated_clk (bus1_clk)
  );

  // rmii_mode comes from sys_clk logic, so it is used without a synchroniser
  assign next_rmii_ref_on = rmii_mode && (hs1_en[BIT_ETH_RX] || hs1_en[BIT_ETH_TX]); // see R8

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rmii_ref_on <= 1'b0;
    end else begin
      rmii_ref_on <= next_rmii_ref_on;
    end
  end

  prcg_clk_gate #(.WIDTH(1)) u_gate_rmii ( // see R8
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    .enable    (rmii_ref_on),
    .held      (rmii_ref_held),
    .gated_clk (rmii_ref_clk)
  );

  // read decode; an unmapped address reads zero
  assign rd_bus2_rst = prcg_hit(reg_addr, OFF_BUS2_RST);
  assign rd_hs1_en   = prcg_hit(reg_addr, OFF_HS1_EN);
  assign rd_hs2_en   = prcg_hit(reg_addr, OFF_HS2_EN);
  assign rd_hs3_en   = prcg_hit(reg_addr, OFF_HS3_EN);
  assign rd_bus1_en  = prcg_hit(reg_addr, OFF_BUS1_EN);

  assign next_rdata = rd_bus2_rst ? bus2_rst :
                      rd_hs1_en   ? hs1_en   :
                      rd_hs2_en   ? hs2_en   :
                      rd_hs3_en   ? hs3_en   :
                      rd_bus1_en  ? bus1_en  : RESET_VALUE;

  // writable bits of the addressed slot; an unmapped slot has none
  assign rd_mask    = rd_bus2_rst ? MASK_BUS2_RST :
                      rd_hs1_en   ? MASK_HS1_EN   :
                      rd_hs2_en   ? MASK_HS2_EN   :
                      rd_hs3_en   ? MASK_HS3_EN   :
                      rd_bus1_en  ? MASK_BUS1_EN  : RESET_VALUE;

  // whole word returned; the master picks its lanes, so narrow reads need no wait
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= RESET_VALUE;
    end else if (reg_rd) begin
      reg_rdata <= next_rdata; // see R10
    end else begin
      reg_rdata <= RESET_VALUE;
    end
  end

  a_audio_reset: assert property (@(posedge sys_clk) disable iff (!rst_n) // see R1
    (reg_wr && prcg_hit(reg_addr, OFF_BUS2_RST) && reg_byte_en[LANE3])
    |=> (audio_ext_b_reset == $past(reg_wdata[BIT_AUDIO_B]))
        && (audio_ext_a_reset == $past(reg_wdata[BIT_AUDIO_A])))
    else $error("audio extension reset did not follow write");

  a_timer_reset: assert property (@(posedge sys_clk) disable iff (!rst_n) // see R2
    (reg_wr && prcg_hit(reg_addr, OFF_BUS2_RST) && reg_byte_en[LANE2])
    |=> ({general_timer_c_reset, general_timer_b_reset, general_timer_a_reset}
         == $past(reg_wdata[BIT_GTIM_C:BIT_GTIM_A])))
    else $error("general timer reset did not follow write");

  a_adv_timer: assert property (@(posedge sys_clk) disable iff (!rst_n) // see R3
    (reg_wr && prcg_hit(reg_addr, OFF_BUS2_RST) && reg_byte_en[LANE0])
    |=> ({advanced_timer_b_reset, advanced_timer_a_reset} == $past(reg_wdata[BIT_ATIM_B:BIT_ATIM_A])))
    else $error("advanced timer reset did not follow write");

  a_serial_reset: assert property (@(posedge sys_clk) disable iff (!rst_n) // see R4
    (reg_wr && prcg_hit(reg_addr, OFF_BUS2_RST) && reg_byte_en[LANE1] && reg_byte_en[LANE0])
    |=> ({serial_periph_d_reset, serial_periph_a_reset} == $past(reg_wdata[BIT_SPI_D:BIT_SPI_A]))
        && ({transceiver_f_reset, transceiver_a_reset} == $past(reg_wdata[BIT_XCVR_F:BIT_XCVR_A])))
    else $error("serial or transceiver reset did not follow write");

  a_misc_reset: assert property (@(posedge sys_clk) disable iff (!rst_n) // see R5
    (reg_wr && prcg_hit(reg_addr, OFF_BUS2_RST) && (reg_byte_en == 4'hf))
    |=> (converter_interface_reset == $past(reg_wdata[BIT_CONV]))
        && (sysconfig_unit_reset == $past(reg_wdata[BIT_SYSCFG]))
        && (clock_calibrator_reset == $past(reg_wdata[BIT_CALIB])))
    else $error("converter, sysconfig or calibrator reset wrong");

  a_resvd_zero: assert property (@(posedge sys_clk) disable iff (!rst_n) // see R6
    reg_rd |=> ((reg_rdata & ~$past(rd_mask)) == RESET_VALUE))
    else $error("reserved bits read nonzero");

  a_port_gate: assert property (@(posedge sys_clk) disable iff (!rst_n) // see R7, R9
    (reg_wr && prcg_hit(reg_addr, OFF_HS1_EN) && reg_byte_en[LANE0])
    |=> (hs1_held[BIT_PORT_H:BIT_PORT_A] == $past(reg_wdata[BIT_PORT_H:BIT_PORT_A])))
    else $error("port clock gate did not follow enable write");

  a_rmii_on: assert property (@(posedge sys_clk) disable iff (!rst_n) // see R8
    (rmii_mode && (hs1_en[BIT_ETH_RX] || hs1_en[BIT_ETH_TX])) |=> rmii_ref_on && rmii_ref_held)
    else $error("reference clock not enabled in reduced mode");

  a_rmii_off: assert property (@(posedge sys_clk) disable iff (!rst_n) // see R8
    !rmii_mode |=> !rmii_ref_on)
    else $error("reference clock on outside reduced mode");

  a_read_word: assert property (@(posedge sys_clk) disable iff (!rst_n) // see R10
    (reg_rd && rd_hs2_en) |=> (reg_rdata == $past(hs2_en)) ##1 ($past(reg_rd) || (reg_rdata == RESET_VALUE)))
    else $error("read data wrong or not one cycle");

  a_wwdg_gate: assert property (@(posedge sys_clk) disable iff (!rst_n) // see R11
    (reg_wr && prcg_hit(reg_addr, OFF_BUS1_EN) && reg_byte_en[LANE1])
    |=> (bus1_held[BIT_WWDG] == $past(reg_wdata[BIT_WWDG])))
    else $error("watchdog clock gate wrong");

  a_can_pwr: assert property (@(posedge sys_clk) disable iff (!rst_n) // see R12
    (reg_wr && prcg_hit(reg_addr, OFF_BUS1_EN) && reg_byte_en[LANE3])
    |=> (bus1_en[BIT_PWR:BIT_CAN_A] == $past(reg_wdata[BIT_PWR:BIT_CAN_A])))
    else $error("power or CAN enable wrong");

  a_reset_hold: assert property (@(posedge sys_clk) disable iff (!rst_n) // see R13
    !(reg_wr && prcg_hit(reg_addr, OFF_BUS2_RST)) |=> $stable(bus2_rst))
    else $error("reset bits changed without a write");

  a_held_phase: assert property (@(posedge sys_clk) disable iff (!rst_n) // see R14
    (hs1_held == hs1_en) && (bus1_held == bus1_en) && (hs2_held == hs2_en) && (hs3_held == hs3_en))
    else $error("gate enable moved outside the low phase");

endmodule : prcg_top

// *** sim/prcg_top_test.sv ***
/*
  Self-checking bench for the peripheral reset and clock gating bank.
  Assumes the register port contract of the top module and a 25 MHz sys_clk.
*/
`timescale 1ns/1ps
module prcg_top_test;
  import prcg_pkg::*;

  typedef struct {
    prcg_addr_type addr;
    prcg_word_type wdata;
    prcg_lane_type be;
    prcg_word_type expect_rd;
  } prcg_row_type;

  logic          sys_clk;
  logic          rst_n;
  prcg_addr_type reg_addr;
  prcg_word_type reg_wdata;
  prcg_lane_type reg_byte_en;
  logic          reg_wr;
  logic          reg_rd;
  prcg_word_type reg_rdata;
  logic          rmii_mode;
  wire  [14:0]   rst_vec;
  prcg_word_type hs1_clk;
  prcg_word_type hs2_clk;
  prcg_word_type hs3_clk;
  prcg_word_type bus1_clk;
  logic          rmii_ref_clk;
  int            bad_count;
  int            checks_done;
  prcg_word_type rd_val;
  prcg_row_type  rows [9];
  prcg_word_type clk_hi;
  prcg_word_type clk_lo;
  int            rst_bits [15] = '{31, 30, 29, 20, 18, 17, 16, 14, 13, 12, 8, 5, 4, 1, 0};
  prcg_addr_type en_offs [4] = '{OFF_HS1_EN, OFF_HS2_EN, OFF_HS3_EN, OFF_BUS1_EN};
  prcg_word_type en_masks [4] = '{MASK_HS1_EN, MASK_HS2_EN, MASK_HS3_EN, MASK_BUS1_EN};

  prcg_top i_prcg_top (
    .sys_clk                   (sys_clk),
    .rst_n                     (rst_n),
    .reg_addr                  (reg_addr),
    .reg_wdata                 (reg_wdata),
    .reg_byte_en               (reg_byte_en),
    .reg_wr                    (reg_wr),
    .reg_rd                    (reg_rd),
    .reg_rdata                 (reg_rdata),
    .rmii_mode                 (rmii_mode),
    .audio_ext_b_reset         (rst_vec[14]),
    .audio_ext_a_reset         (rst_vec[13]),
    .clock_calibrator_reset    (rst_vec[12]),
    .fullduplex_audio_reset    (rst_vec[11]),
    .general_timer_c_reset     (rst_vec[10]),
    .general_timer_b_reset     (rst_vec[9]),
    .general_timer_a_reset     (rst_vec[8]),
    .sysconfig_unit_reset      (rst_vec[7]),
    .serial_periph_d_reset     (rst_vec[6]),
    .serial_periph_a_reset     (rst_vec[5]),
    .converter_interface_reset (rst_vec[4]),
    .transceiver_f_reset       (rst_vec[3]),
    .transceiver_a_reset       (rst_vec[2]),
    .advanced_timer_b_reset    (rst_vec[1]),
    .advanced_timer_a_reset    (rst_vec[0]),
    .hs1_clk                   (hs1_clk),
    .hs2_clk                   (hs2_clk),
    .hs3_clk                   (hs3_clk),
    .bus1_clk                  (bus1_clk),
    .rmii_ref_clk              (rmii_ref_clk)
  );

  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  task automatic check(input string name, input prcg_word_type exp, input prcg_word_type got);
    checks_done++;
    if (got !== exp) begin
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
      bad_count++;
    end
  endtask : check

  task automatic wr(input prcg_addr_type a, input prcg_word_type d, input prcg_lane_type be);
    @(posedge sys_clk);
    reg_wr      <= 1'b1;
    reg_addr    <= a;
    reg_wdata   <= d;
    reg_byte_en <= be;
    @(posedge sys_clk);
    reg_wr      <= 1'b0;
  endtask : wr

  // read data stand only in the cycle after the strobe
  task automatic rd(input prcg_addr_type a, output prcg_word_type d);
    @(posedge sys_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd   <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : rd

  // gated clocks sampled mid high phase and mid low phase
  task automatic sample_clks(input int sel, output prcg_word_type hi, output prcg_word_type lo);
    prcg_word_type v [4];
    @(posedge sys_clk);
    #10;
    v = '{hs1_clk, hs2_clk, hs3_clk, bus1_clk};
    hi = v[sel];
    @(negedge sys_clk);
    #10;
    v = '{hs1_clk, hs2_clk, hs3_clk, bus1_clk};
    lo = v[sel];
  endtask : sample_clks

  task automatic print_verdict;
    if (bad_count == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : print_verdict

  initial begin
    #(40 * 4000);
    bad_count++;
    print_verdict();
  end

  initial begin
    bad_count   = 0;
    checks_done = 0;
    rst_n       = 1'b0;
    reg_addr    = 8'h00;
    reg_wdata   = 32'h0000_0000;
    reg_byte_en = 4'h0;
    reg_wr      = 1'b0;
    reg_rd      = 1'b0;
    rmii_mode   = 1'b0;
    rows = '{
      '{OFF_BUS2_RST, 32'hffff_ffff, 4'hf, MASK_BUS2_RST},
      '{OFF_HS1_EN,   32'hffff_ffff, 4'hf, MASK_HS1_EN},
      '{OFF_HS2_EN,   32'hffff_ffff, 4'hf, MASK_HS2_EN},
      '{OFF_HS3_EN,   32'hffff_ffff, 4'hf, MASK_HS3_EN},
      '{OFF_BUS1_EN,  32'hffff_ffff, 4'hf, MASK_BUS1_EN},
      '{8'h14,        32'hffff_ffff, 4'hf, 32'h0000_0000},
      '{OFF_BUS2_RST, 32'h0000_0000, 4'h1, 32'he017_7100},
      '{8'h02,        32'h0000_0000, 4'hc, 32'h0000_7100},
      '{OFF_BUS2_RST, 32'h0000_0000, 4'h2, 32'h0000_0000}
    };
    repeat (10) @(posedge sys_clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      rd(8'h00 + 8'(i * 4), rd_val);
      check("reset value", RESET_VALUE, rd_val);
    end
    check("reset pins idle", 32'h0, {17'h0, rst_vec});
    // table rows, with byte-lane and unmapped-slot writes: write then read back the whole word
    foreach (rows[i]) begin
      wr(rows[i].addr, rows[i].wdata, rows[i].be);
      rd(rows[i].addr, rd_val);
      check("row readback", rows[i].expect_rd, rd_val);
    end
    @(posedge sys_clk);
    #1;
    check("read data after slot", 32'h0, reg_rdata);
    // each reset line alone, held until cleared
    foreach (rst_bits[i]) begin
      wr(OFF_BUS2_RST, 32'h1 << rst_bits[i], 4'hf);
      repeat (8) @(posedge sys_clk);
      #1;
      check("reset line", 32'h1 << (14 - i), {17'h0, rst_vec});
    end
    wr(OFF_BUS2_RST, 32'h0, 4'hf);
    #1;
    check("reset lines released", 32'h0, {17'h0, rst_vec});
    // every enable register's gates: enabled bits follow sys_clk, the rest stay low
    for (int s = 0; s < 4; s++) begin
      wr(en_offs[s], 32'hffff_ffff, 4'hf);
      repeat (2) @(posedge sys_clk);
      sample_clks(s, clk_hi, clk_lo);
      check("gated clock high phase", en_masks[s], clk_hi);
      check("gated clock low phase", 32'h0, clk_lo);
      wr(en_offs[s], 32'h0, 4'hf);
      repeat (2) @(posedge sys_clk);
      sample_clks(s, clk_hi, clk_lo);
      check("gated clock off", 32'h0, clk_hi);
    end
    // no reference clock from an ethernet enable outside reduced mode
    wr(OFF_HS1_EN, 32'h1 << 27, 4'hf);
    repeat (3) @(posedge sys_clk);
    #10;
    check("reference clock outside mode", 32'h0, {31'h0, rmii_ref_clk});
    // reduced-mode reference from either ethernet enable
    @(posedge sys_clk);
    rmii_mode <= 1'b1;
    for (int b = 26; b < 28; b++) begin
      wr(OFF_HS1_EN, 32'h1 << b, 4'hf);
      repeat (3) @(posedge sys_clk);
      #10;
      check("reference clock high", 32'h1, {31'h0, rmii_ref_clk});
      @(negedge sys_clk);
      #10;
      check("reference clock low", 32'h0, {31'h0, rmii_ref_clk});
    end
    wr(OFF_HS1_EN, 32'h0, 4'hf);
    repeat (3) @(posedge sys_clk);
    #10;
    check("reference clock off", 32'h0, {31'h0, rmii_ref_clk});
    // reset in mid run clears a live register and its lines
    wr(OFF_BUS2_RST, 32'hffff_ffff, 4'hf);
    @(posedge sys_clk);
    rst_n <= 1'b0;
    #5;
    check("lines in reset", 32'h0, {17'h0, rst_vec});
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    rd(OFF_BUS2_RST, rd_val);
    check("value after reset", RESET_VALUE, rd_val);
    print_verdict();
  end

endmodule : prcg_top_test
